// >>> pbs_pkg.sv
// Shared types and constants for the pipelined burst SRAM port.
// Assumes a single clock domain at 100 MHz; no software-visible registers.
package pbs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS            = 10;
  localparam int SLEEP_ENTER_CYCLES_NS    = 20;  // Two cycles to enter
  localparam int SLEEP_RECOVERY_INTERVAL_NS = 20; // Two cycles to leave
  localparam int SLEEP_ENTER_CYC = (SLEEP_ENTER_CYCLES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_EXIT_CYC  = (SLEEP_RECOVERY_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SLEEP_ENTER_CNT = 2'(SLEEP_ENTER_CYC);
  localparam logic [1:0] SLEEP_EXIT_CNT  = 2'(SLEEP_EXIT_CYC);

  // ----------------------------------------------------------------
  // Burst and reset values
  // ----------------------------------------------------------------
  localparam int         BURST_BITS     = 2;
  localparam logic [1:0] BEAT_RST       = 2'h0;
  localparam logic       BURST_ORDER_LINEAR = 1'b0;

  // Sleep controller states
  typedef enum logic [2:0] {
    PBS_AWAKE    = 3'b001,
    PBS_ENTERING = 3'b010,
    PBS_ASLEEP   = 3'b100
  } pbs_sleep_e;

  // Command sampled at a qualified edge
  typedef struct packed {
    logic       active;   // Access (not deselect)
    logic       is_write;
    logic [1:0] start;    // Loaded low address bits
    logic [1:0] beat;     // Beat index within the burst
  } pbs_burst_s;

endpackage

// >>> pbs_sram_port.sv
// Synchronous access port of a pipelined, zero-turnaround burst SRAM.
// Assumes inputs other than sleep request and output enable synchronous to clk; the controller resolves bus wires from the enables.
// Functional notes
// [RULE1] Read starts on qualified, selected, strobe high, load
// [RULE2] Read word driven after next edge
// [RULE3] Drivers gated by output enable after first cycle
// [RULE4] New command accepted right after a read
// [RULE5] Deselect tri-states after the next edge
// [RULE6] Burst counter serves up to four beats
// [RULE7] Order select low linear, high interleaved
// [RULE8] Only two low address bits wrap
// [RULE9] Advance steps counter, ignores selects and strobe
// [RULE10] Direction kept for the whole burst
// [RULE11] Write starts with strobe low, latches byte selects
// [RULE12] Data lines tri-stated edge after write
// [RULE13] Write data captured second edge after command
// [RULE14] Only enabled byte lanes are updated
// [RULE15] Controller avoids driving while outputs active
// [RULE16] Controller supplies byte mask every beat
// [RULE17] Sleep request asynchronous, two cycles enter/exit
// [RULE18] Contents kept while asleep
// [RULE19] Controller deselects before requesting sleep
// [RULE20] Selects stay inactive during recovery interval
// [RULE21] Linear order counts upward modulo four
// [RULE22] Interleaved order XORs start with beat
// [RULE23] Disqualified edge holds all state; the sleep synchroniser and sleep controller still advance on it
// [RULE24] Output enable gates drivers without clock
`timescale 1ns/10ps
module pbs_sram_port
  import pbs_pkg::*;
#(
  parameter int ADDR_W  = 10,
  parameter int LANES   = 4,
  parameter int DEPTH   = 1024
) (
  input  wire logic                 clk,               // Core clock
  input  wire logic                 rst_n,             // Async reset, active low
  input  wire logic                 clock_qualifier_n, // Low qualifies the edge
  input  wire logic                 chip_select_1_n,   // Select, active low
  input  wire logic                 chip_select_2,     // Select, active high
  input  wire logic                 chip_select_3_n,   // Select, active low
  input  wire logic                 advance_or_load,   // High advance, low load
  input  wire logic                 write_strobe_n,    // Low writes at load
  input  wire logic [LANES-1:0]     byte_lane_write_n, // Per-lane write, active low
  input  wire logic [ADDR_W-1:0]    addr,              // Address inputs
  input  wire logic                 burst_order,       // Low linear, high interleaved
  input  wire logic                 output_drive_en_n, // Async output enable, active low
  input  wire logic                 sleep_request,     // Async sleep input
  input  wire logic [LANES*8-1:0]   data_lines_in,     // Data pins as seen
  input  wire logic [LANES-1:0]     parity_lines_in,   // Parity pins as seen
  output logic      [LANES*8-1:0]   data_lines_out,    // Read data
  output logic      [LANES-1:0]     parity_lines_out,  // Read parity
  output logic                      data_lines_oe,     // High while driving data and parity
  output logic                      asleep             // Sleep state flag
);

  localparam int W = LANES * 9;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Pipeline state
  // ----------------------------------------------------------------
  pbs_burst_s          burst_q, burst_d;
  logic [ADDR_W-1:0]   base_q, base_d;
  logic                order_q, order_d;
  logic                rd_p1_q, rd_p1_d;           // Read latched, word fetched next edge
  logic                wr_p1_q, wr_p1_d;           // Write latched, drivers off next edge
  logic [ADDR_W-1:0]   p1_addr_q, p1_addr_d;       // Address of the latched access
  logic [LANES-1:0]    p1_mask_q, p1_mask_d;       // Lane selects of the latched beat
  logic                wr_p2_q, wr_p2_d;           // Write awaiting data
  logic [ADDR_W-1:0]   wr_addr_q, wr_addr_d;
  logic [LANES-1:0]    wr_mask_q, wr_mask_d;
  logic                rd_valid_q, rd_valid_d;     // Output register holds read data
  logic [W-1:0]        rd_data_q, rd_data_d;
  logic                oe_q;
  logic                asleep_q;
  pbs_sleep_e          sleep_q, sleep_d;
  logic [1:0]          scnt_q, scnt_d;
  logic                sreq_s1_q, sreq_s2_q;
  logic                qual, sel_all, load, adv, acc_now, acc_wr;
  logic [1:0]          beat_nx, low_bits;
  logic [ADDR_W-1:0]   acc_addr;
  logic [W-1:0]        wdata, merged;

  // Sleep request synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sreq_s1_q <= 1'b0;
      sreq_s2_q <= 1'b0;
    end else begin
      sreq_s1_q <= sleep_request; // RULE17
      sreq_s2_q <= sreq_s1_q;
    end
  end

  // Sleep controller: count two cycles in and two out
  always_comb begin
    sleep_d = sleep_q;
    scnt_d  = scnt_q;
    case (sleep_q)
      PBS_AWAKE: begin
        scnt_d = 2'h0;
        if (sreq_s2_q) begin
          sleep_d = PBS_ENTERING; // RULE17
          scnt_d  = 2'h1;
        end
      end
      PBS_ENTERING: begin
        if (!sreq_s2_q) begin
          sleep_d = PBS_AWAKE;
        end else if (scnt_q >= SLEEP_ENTER_CNT - 2'h1) begin
          sleep_d = PBS_ASLEEP;
          scnt_d  = 2'h0;
        end else begin
          scnt_d = scnt_q + 2'h1;
        end
      end
      PBS_ASLEEP: begin
        if (!sreq_s2_q) begin
          scnt_d = scnt_q + 2'h1;
          if (scnt_q >= SLEEP_EXIT_CNT - 2'h1) begin
            sleep_d = PBS_AWAKE; // RULE17
          end
        end else begin
          scnt_d = 2'h0;
        end
      end
      default: sleep_d = PBS_AWAKE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_q  <= PBS_AWAKE;
      scnt_q   <= 2'h0;
      asleep_q <= 1'b0;
    end else begin
      sleep_q  <= sleep_d;
      scnt_q   <= scnt_d;
      asleep_q <= (sleep_d == PBS_ASLEEP); // Flag leaves the block from a flop
    end
  end

  // Command decode; edges are ignored while asleep or disqualified
  assign qual    = !clock_qualifier_n && (sleep_q == PBS_AWAKE); // RULE23
  assign sel_all = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign load    = qual && !advance_or_load;
  assign adv     = qual && advance_or_load && burst_q.active; // RULE9

  // Burst address: only the low two bits move, upper bits held
  assign beat_nx  = burst_q.beat + 2'h1; // RULE6
  assign low_bits = order_q ? (burst_q.start ^ beat_nx)     // RULE22
                            : (burst_q.start + beat_nx);    // RULE21
  assign acc_now  = load ? sel_all : adv;
  assign acc_wr   = load ? !write_strobe_n : burst_q.is_write; // RULE10
  assign acc_addr = load ? addr : {base_q[ADDR_W-1:2], low_bits}; // RULE8

  // Byte-lane merge of incoming write data with stored word
  always_comb begin
    wdata  = '0;
    merged = mem[wr_addr_q];
    for (int i = 0; i < LANES; i++) begin
      wdata[i*9 +: 9] = {parity_lines_in[i], data_lines_in[i*8 +: 8]};
      if (!wr_mask_q[i]) begin
        merged[i*9 +: 9] = wdata[i*9 +: 9]; // RULE14
      end
    end
  end

  // Next state of the access pipeline
  always_comb begin
    burst_d    = burst_q;
    base_d     = base_q;
    order_d    = order_q;
    rd_p1_d    = rd_p1_q;
    wr_p1_d    = wr_p1_q;
    p1_addr_d  = p1_addr_q;
    p1_mask_d  = p1_mask_q;
    wr_p2_d    = wr_p2_q;
    wr_addr_d  = wr_addr_q;
    wr_mask_d  = wr_mask_q;
    rd_valid_d = rd_valid_q;
    rd_data_d  = rd_data_q;
    if (sleep_q != PBS_AWAKE) begin
      burst_d    = '0;      // Pending accesses dropped, memory kept
      rd_p1_d    = 1'b0;
      wr_p1_d    = 1'b0;    // RULE18
      wr_p2_d    = 1'b0;
      rd_valid_d = 1'b0;
    end else if (qual) begin
      if (load) begin
        burst_d.active   = sel_all;         // RULE1 RULE11
        burst_d.is_write = !write_strobe_n; // RULE10
        burst_d.start    = addr[1:0];
        burst_d.beat     = BEAT_RST;
        base_d           = addr;
        order_d          = burst_order;     // RULE7
      end else if (adv) begin
        burst_d.beat = beat_nx;
      end
      // First stage: latch the access at its own command edge
      rd_p1_d    = acc_now && !acc_wr;       // RULE4
      wr_p1_d    = acc_now && acc_wr;
      p1_addr_d  = acc_addr;
      p1_mask_d  = byte_lane_write_n;        // RULE16
      // Second stage: load the output register, or turn the bus for write data
      rd_valid_d = rd_p1_q;                  // RULE2 RULE5 RULE12
      wr_p2_d    = wr_p1_q;
      wr_addr_d  = p1_addr_q;
      wr_mask_d  = p1_mask_q;
      if (rd_p1_q) begin
        // Forward a write landing at this very edge, else the read sees the old word
        if (wr_p2_q && (wr_addr_q == p1_addr_q)) begin
          rd_data_d = merged;
        end else begin
          rd_data_d = mem[p1_addr_q];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_q    <= '0;
      base_q     <= '0;
      order_q    <= BURST_ORDER_LINEAR;
      rd_p1_q    <= 1'b0;
      wr_p1_q    <= 1'b0;
      p1_addr_q  <= '0;
      p1_mask_q  <= '1;
      wr_p2_q    <= 1'b0;
      wr_addr_q  <= '0;
      wr_mask_q  <= '1;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      burst_q    <= burst_d;
      base_q     <= base_d;
      order_q    <= order_d;
      rd_p1_q    <= rd_p1_d;
      wr_p1_q    <= wr_p1_d;
      p1_addr_q  <= p1_addr_d;
      p1_mask_q  <= p1_mask_d;
      wr_p2_q    <= wr_p2_d;
      wr_addr_q  <= wr_addr_d;
      wr_mask_q  <= wr_mask_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
    end
  end

  // Array write at the second edge after the command; no reset on storage
  always_ff @(posedge clk) begin
    if (wr_p2_q && qual) begin
      mem[wr_addr_q] <= merged; // RULE13
    end
  end

  // Output-enable flop follows read valid; the enable pin is never sampled,
  // so a late fall of the enable still turns the drivers on within the cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= rd_valid_d; // RULE3
    end
  end

  // Outputs; async output enable drops the drivers mid-cycle
  always_comb begin
    data_lines_oe = oe_q && !output_drive_en_n; // RULE24
    for (int i = 0; i < LANES; i++) begin
      data_lines_out[i*8 +: 8] = rd_data_q[i*9 +: 8];
      parity_lines_out[i]      = rd_data_q[i*9 + 8];
    end
    asleep = asleep_q;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence read_load_s;
    qual && load && sel_all && write_strobe_n;
  endsequence

  sequence write_load_s;
    qual && load && sel_all && !write_strobe_n;
  endsequence

  sequence desel_load_s;
    qual && load && !sel_all;
  endsequence

  read_valid_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    read_load_s ##1 qual |=> rd_valid_q) else $error("read not valid after load");
  write_tri_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    write_load_s ##1 qual |=> !data_lines_oe) else $error("drive after write");
  desel_tri_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    desel_load_s ##1 qual |=> !rd_valid_q) else $error("deselect not tri-stated");
  hold_edge_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE23
    (clock_qualifier_n && sleep_q == PBS_AWAKE) |=> $stable(burst_q) && $stable(rd_valid_q))
    else $error("state moved on ignored edge");
  dir_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    adv |=> burst_q.is_write == $past(burst_q.is_write)) else $error("direction changed");
  upper_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    adv |-> acc_addr[ADDR_W-1:2] == base_q[ADDR_W-1:2]) else $error("upper bits moved");
  lin_order_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    (adv && !order_q) |-> low_bits == burst_q.start + burst_q.beat + 2'h1) else $error("linear order");
  oe_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE24
    output_drive_en_n |-> !data_lines_oe) else $error("driving with enable high");
  wr_capture_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    write_load_s ##1 qual |=> wr_p2_q) else $error("write not pending");
  sleep_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    (sleep_q != PBS_AWAKE) |=> !rd_valid_q && !wr_p2_q) else $error("access survived sleep");
  il_third_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
    (adv && order_q && burst_q.beat == 2'h1) |-> low_bits == {~burst_q.start[1], burst_q.start[0]})
    else $error("interleaved third beat");

endmodule

// >>> pbs_ctrl_model.sv
// Controller-side pin model for the burst SRAM port bench.
// Assumes the bench tells it when write data is due; it resolves the shared pins.
`timescale 1ns/10ps
module pbs_ctrl_model
  import pbs_pkg::*;
(
  input  wire logic        clk,    // Core clock
  input  wire logic        dev_oe, // Device drives the pins
  input  wire logic [35:0] dev_q,  // Device parity and data
  input  wire logic        drv,    // Controller drives write data
  input  wire logic [35:0] wr_d,   // Controller parity and data
  output logic      [35:0] pins    // Resolved pin level
);
  logic [35:0] last_q;

  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Released pins show the inverse of the last level, so a stale copy never passes
  always_comb begin
    if (dev_oe && drv)
      pins = 'x;         // Contention shows as unknown
    else if (dev_oe)
      pins = dev_q;
    else if (drv)
      pins = wr_d;
    else
      pins = ~last_q;
  end

  // Last level seen, for the released-pin pattern
  always_ff @(posedge clk)
    last_q <= pins;
endmodule

// >>> tb.sv
// Self-checking bench for the burst SRAM port.
// Assumes default design parameters; the controller model resolves the pins.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb
  import pbs_pkg::*;
;
  typedef struct packed {
    logic [9:0]  a;
    logic [3:0]  m;
    logic [35:0] w;
    logic [35:0] x;
  } pbs_tb_row_s;

  logic        clk, rst_n, clock_qualifier_n, chip_select_1_n, chip_select_2, chip_select_3_n;
  logic        advance_or_load, write_strobe_n, burst_order, output_drive_en_n, sleep_request;
  logic        data_lines_oe, asleep, drv;
  logic [3:0]  byte_lane_write_n, parity_lines_out;
  logic [9:0]  addr;
  logic [31:0] data_lines_out;
  logic [35:0] wr_d, pins;
  logic [36:0] e1, e2;
  int          err_count = 0;
  int          check_count = 0;
  // Write then read back; rows 1 and 2 merge lanes, row 4 writes no lane
  pbs_tb_row_s rows [5] = '{
    '{10'h004, 4'h0, 36'h5_11223344, 36'h5_11223344},
    '{10'h004, 4'hE, 36'hA_AABBCCDD, 36'h4_112233DD},
    '{10'h004, 4'h6, 36'hF_99887766, 36'hD_99223366},
    '{10'h3FF, 4'h0, 36'h3_0F0F0F0F, 36'h3_0F0F0F0F},
    '{10'h3FF, 4'hF, 36'hC_FFFFFFFF, 36'h3_0F0F0F0F}};

  pbs_sram_port u_pbs_sram_port (.clk, .rst_n, .clock_qualifier_n, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .advance_or_load, .write_strobe_n, .byte_lane_write_n, .addr, .burst_order,
    .output_drive_en_n, .sleep_request, .data_lines_in(pins[31:0]), .parity_lines_in(pins[35:32]),
    .data_lines_out, .parity_lines_out, .data_lines_oe, .asleep);
  pbs_ctrl_model u_pbs_ctrl_model (.clk, .dev_oe(data_lines_oe),
    .dev_q({parity_lines_out, data_lines_out}), .drv, .wr_d, .pins);

  // ----------------------------------------------------------------
  // Clock, helpers and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Burst word keyed by the two low address bits
  function automatic logic [35:0] bdat(input int i);
    return {4'(i), 32'hA5A5_0000 + 32'(i)};
  endfunction

  // One command per cycle; the beat launched two calls back is judged here
  task automatic step(input logic s, adv, wn, o, input logic [3:0] m, input logic [9:0] a,
                      input logic [36:0] w, e);
    @(posedge clk);
    {chip_select_1_n, chip_select_2, chip_select_3_n} <= {!s, s, !s};
    {advance_or_load, write_strobe_n, burst_order} <= {adv, wn, o};
    {byte_lane_write_n, addr, drv, wr_d} <= {m, a, w};
    @(negedge clk);
    `CHK(data_lines_oe, e2[36] & !output_drive_en_n)
    if (e2[36]) `CHK({parity_lines_out, data_lines_out}, e2[35:0])
    e2 = e1;
    e1 = e;
  endtask

  task automatic complete_run();
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far beyond the 65 or so cycles the sequence needs
  initial begin
    #20000;
    err_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clock_qualifier_n, sleep_request, drv, burst_order, advance_or_load} = '0;
    {chip_select_1_n, chip_select_2, chip_select_3_n, write_strobe_n} = 4'b1011;
    {byte_lane_write_n, addr, wr_d, output_drive_en_n} = '0;
    {e1, e2} = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({data_lines_oe, asleep}, 2'b00)
    // Table rows: write, two idle beats, read back, next write at once
    foreach (rows[i]) begin
      step(1, 0, 0, 0, rows[i].m, rows[i].a, 0, 0);
      step(0, 0, 1, 0, 4'hF, 0, 0, 0);
      step(0, 0, 1, 0, 4'hF, 0, {1'b1, rows[i].w}, 0);
      step(1, 0, 1, 0, 4'hF, rows[i].a, 0, {1'b1, rows[i].x});
    end
    // Linear burst write from 01; selects and address ignored while advancing
    step(1, 0, 0, 0, 4'h0, 10'h011, 0, 0);
    for (int k = 1; k < 6; k++)
      step(0, k < 4, k >= 4, 0, k < 4 ? 4'h0 : 4'hF, 10'h3FF, {k > 1, bdat((k - 1) & 3)}, 0);
    // Back-to-back bursts: linear from 11, then interleaved from 01
    for (int o = 0; o < 2; o++)
      for (int k = 0; k < 4; k++)
        step(k == 0, k > 0, k == 0, o[0], 4'hF, {8'h04, o ? 2'b01 : 2'b11}, 0,
             {1'b1, bdat(o ? (1 ^ k) : ((3 + k) & 3))});
    step(0, 0, 1, 0, 4'hF, 0, 0, 0);
    step(0, 0, 1, 0, 4'hF, 0, 0, 0);
    // Stall while read data stands, with the enable toggled mid-cycle
    step(1, 0, 1, 0, 4'hF, 10'h004, 0, 0);
    step(0, 0, 1, 0, 4'hF, 0, 0, 0);
    @(posedge clk);
    clock_qualifier_n <= 1'b1;
    repeat (4) @(posedge clk);
    clock_qualifier_n <= 1'b0;
    @(negedge clk);
    `CHK({data_lines_oe, parity_lines_out, data_lines_out}, {1'b1, 36'hD_99223366})
    output_drive_en_n <= 1'b1;
    #1 `CHK(data_lines_oe, 1'b0)
    output_drive_en_n <= 1'b0;
    #1 `CHK(data_lines_oe, 1'b1)
    @(negedge clk);
    `CHK(data_lines_oe, 1'b0)
    // Sleep while deselected; selects stay off through recovery
    @(posedge clk);
    sleep_request <= 1'b1;
    @(negedge clk);
    `CHK(asleep, 1'b0)
    repeat (3) @(negedge clk);
    `CHK(asleep, 1'b0)
    repeat (2) @(negedge clk);
    `CHK(asleep, 1'b1)
    @(posedge clk);
    sleep_request <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK(asleep, 1'b1)
    repeat (2) @(negedge clk);
    `CHK(asleep, 1'b0)
    step(1, 0, 1, 0, 4'hF, 10'h004, 0, {1'b1, 36'hD_99223366});
    step(0, 0, 1, 0, 4'hF, 0, 0, 0);
    step(0, 0, 1, 0, 4'hF, 0, 0, 0);
    complete_run();
  end
endmodule
